// [verilog/bus_sizing_pkg.sv]
// Shared constants and carrier types for the bus sizing sequencer
package bus_sizing_pkg;

  localparam int ADDR_W = 32;
  localparam int DATA_W = 32;

  // Remaining byte counts; the low two bits are the size outputs
  localparam logic [2:0] REM_BYTE = 3'h1;
  localparam logic [2:0] REM_WORD = 3'h2;
  localparam logic [2:0] REM_LONG = 3'h4;

  // Acknowledge pair {size_ack_hi, size_ack_lo}
  localparam logic [1:0] ACK_WAIT = 2'h0;
  localparam logic [1:0] ACK_8    = 2'h1;
  localparam logic [1:0] ACK_16   = 2'h2;
  localparam logic [1:0] ACK_32   = 2'h3;

  // Operand end status
  localparam logic [1:0] STAT_OK    = 2'h0;
  localparam logic [1:0] STAT_BUS_ERROR_IN  = 2'h1;
  localparam logic [1:0] STAT_RETRY = 2'h2;
  localparam logic [1:0] STAT_AUTOVECTOR_REQ  = 2'h3;

  // Values after reset
  localparam logic [ADDR_W-1:0] ADDR_RST = 32'h0000_0000;
  localparam logic [DATA_W-1:0] DATA_RST = 32'h0000_0000;
  localparam logic [2:0]        REM_RST  = 3'h4;
  localparam logic [1:0]        STAT_RST = 2'h0;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_SETUP = 2'b01,
    ST_RUN   = 2'b10,
    ST_GAP   = 2'b11
  } seq_state_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;   // First byte address
    logic [2:0]        nbytes; // 1, 2 or 4
    logic              write;
    logic              intack; // Interrupt acknowledge cycle
    logic [DATA_W-1:0] wdata;  // Operand, right justified
  } op_req_t;

  typedef struct packed {
    logic [DATA_W-1:0] rdata;  // Operand, right justified
    logic [1:0]        status;
  } op_rsp_t;

  typedef struct packed {
    logic              size_ack_hi;
    logic              size_ack_lo;
    logic              bus_error_in;
    logic              halt_in;
    logic              autovector_req;
    logic [DATA_W-1:0] data;
  } bus_in_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic              xfer_size_hi;
    logic              xfer_size_lo;
    logic              rd_wr_n;
    logic              strobe;
    logic [DATA_W-1:0] data;
    logic              data_oe_n;
  } bus_out_t;

endpackage : bus_sizing_pkg

// [verilog/pin_sync.sv]
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ns

module pin_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             ref_clk,   // Sampling clock
  input  wire logic             rst,       // Async reset, active high
  input  wire logic [WIDTH-1:0] pin_in,    // Raw pins
  output logic      [WIDTH-1:0] level_out  // Filtered level
);

  logic [WIDTH-1:0] s1_q;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // Each bit moves only once the second and third stages agree
  genvar g;
  for (g = 0; g < WIDTH; g++) begin : g_bit
    always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
        level_out[g] <= 1'b0;
      end else if (s2_q[g] == s3_q[g]) begin
        level_out[g] <= s3_q[g];
      end
    end
  end

endmodule : pin_sync

// [verilog/bus_sizing_seq.sv]
// Operand sequencer: cycle termination, dynamic sizing, byte lanes
// What this block does
// - Read ends on acknowledge; data captured
// - No acknowledge keeps cycle in wait
// - Acknowledge pair encodes 8, 16, 32 bits
// - Bus error alone ends cycle as error
// - Bus error with acknowledge still error
// - Bus error plus halt means retry
// - Autovector ends interrupt acknowledge only
// - Port width decoded fresh every cycle
// - Long read: 16-bit two, 8-bit four cycles
// - Every cycle tries the largest transfer
// - Operand byte0 most significant, byte3 least
// - Any operand byte reaches any lane
// - Size outputs give bytes still remaining
// - Bytes moved may be fewer than size
// - Upper address base, low bits offset
// - Misaligned operands split into more cycles
`timescale 1ns/1ns

module bus_sizing_seq
  import bus_sizing_pkg::*;
(
  input  wire logic     ref_clk,   // 10 MHz clock
  input  wire logic     rst,       // Async reset, active high
  input  wire logic     req_valid, // Operand request
  output logic          req_ready, // Sequencer idle
  input  wire op_req_t  req,       // Request fields
  output logic          rsp_valid, // Operand finished, one cycle
  output op_rsp_t       rsp,       // Read data and status
  input  wire bus_in_t  pins_in,   // Raw bus inputs
  output bus_out_t      pins_out   // Bus outputs
);

  seq_state_t        state_q;
  bus_in_t           pin_s;
  logic [ADDR_W-1:0] addr_q;
  logic [2:0]        rem_q;
  logic              write_q;
  logic              intack_q;
  logic [DATA_W-1:0] op_q;
  logic [DATA_W-1:0] data_q;
  logic              done_q;
  logic [1:0]        status_q;

  logic [1:0]        ack;
  logic              ack_any;
  logic              term_autovector_req;
  logic              term_ack;
  logic              term_any;
  logic              in_run;
  logic              last;
  logic              accept;
  logic [2:0]        room;
  logic [2:0]        moved;
  logic [DATA_W-1:0] rd_next;
  logic [DATA_W-1:0] wr_mux;

  // Every control input, data included, takes the same path so the
  // data seen with an acknowledge is as old as the acknowledge.
  pin_sync #(
    .WIDTH ($bits(bus_in_t))
  ) u_sync (
    .ref_clk   (ref_clk),
    .rst       (rst),
    .pin_in    (pins_in),
    .level_out (pin_s)
  );

  // Byte j of a word, byte 0 in the top lane
  function automatic logic [7:0] byte_of(input logic [31:0] w,
                                         input logic [1:0]  j);
    return w[{~j, 3'b000} +: 8];
  endfunction : byte_of

  // Bytes the answering port can take from this offset
  function automatic logic [2:0] port_room(input logic [1:0] code,
                                           input logic [1:0] off);
    logic [2:0] r;
    unique case (code)
      ACK_32:        r = 3'h4 - {1'b0, off};
      ACK_16:        r = 3'h2 - {2'b00, off[0]};
      ACK_8, ACK_WAIT: r = 3'h1;
    endcase
    return r;
  endfunction : port_room

  // Lane that carries the k-th moved byte on a read
  function automatic logic [1:0] read_lane(input logic [1:0] code,
                                           input logic [1:0] off,
                                           input logic [1:0] k);
    logic [1:0] l;
    unique case (code)
      ACK_32:        l = off + k;
      ACK_16:        l = {1'b0, off[0]} + k;
      ACK_8, ACK_WAIT: l = 2'h0;
    endcase
    return l;
  endfunction : read_lane

  // Operand byte driven on a write lane; lanes below the offset
  // repeat the bytes a narrower port would see there.
  function automatic logic [1:0] write_pick(input logic [2:0] rem,
                                            input logic [1:0] off,
                                            input logic [1:0] lane);
    logic [2:0] idx;
    idx = 3'h0;
    if (rem == REM_BYTE) begin
      idx = 3'h0;
    end else if (lane >= off) begin
      idx = {1'b0, 2'(lane - off)};
    end else if (lane >= {1'b0, off[0]}) begin
      idx = {1'b0, 2'(lane - {1'b0, off[0]})};
    end
    if (idx >= rem) begin
      idx = idx - 3'h2;
    end
    return 2'(3'h4 - rem + idx);
  endfunction : write_pick

  assign ack       = {pin_s.size_ack_hi, pin_s.size_ack_lo};
  assign ack_any   = |ack;
  assign in_run    = (state_q == ST_RUN);
  assign accept    = req_valid && req_ready;
  // Autovector only counts in interrupt acknowledge cycles
  assign term_autovector_req = intack_q && pin_s.autovector_req
                     && !pin_s.bus_error_in;
  // Bus error overrides any acknowledge that comes with it
  assign term_ack  = ack_any && !pin_s.bus_error_in && !term_autovector_req;
  assign term_any  = ack_any || pin_s.bus_error_in || term_autovector_req;

  // Width comes from this cycle's acknowledge only, nothing stored
  assign room  = port_room(ack, addr_q[1:0]);
  assign moved = (rem_q < room) ? rem_q : room;
  assign last  = (moved == rem_q);

  // Read capture into operand byte positions
  always_comb begin
    rd_next = op_q;
    for (int k = 0; k < 4; k++) begin
      if (3'(k) < moved) begin
        rd_next[{~(2'(3'h4 - rem_q + 3'(k))), 3'b000} +: 8] =
          byte_of(pin_s.data, read_lane(ack, addr_q[1:0], 2'(k)));
      end
    end
  end

  genvar g;
  for (g = 0; g < 4; g++) begin : g_lane
    assign wr_mux[{~2'(g), 3'b000} +: 8] =
      byte_of(op_q, write_pick(rem_q, addr_q[1:0], 2'(g)));
  end

  // Sequence control
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_q <= ST_IDLE;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          if (accept) begin
            state_q <= ST_SETUP;
          end
        end
        ST_SETUP: begin
          state_q <= ST_RUN;
        end
        ST_RUN: begin
          if (term_ack && !last) begin
            state_q <= ST_GAP;
          end else if (term_any) begin
            state_q <= ST_IDLE;
          end
        end
        ST_GAP: begin
          // Old terminations must clear before the next cycle
          if (!term_any) begin
            state_q <= ST_SETUP;
          end
        end
      endcase
    end
  end

  // Address and remaining count
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      addr_q   <= ADDR_RST;
      rem_q    <= REM_RST;
      write_q  <= 1'b0;
      intack_q <= 1'b0;
    end else if (accept) begin
      addr_q   <= req.addr;
      rem_q    <= req.nbytes;
      write_q  <= req.write;
      intack_q <= req.intack;
    end else if (in_run && term_ack && !last) begin
      addr_q <= addr_q + ADDR_W'(moved);
      rem_q  <= rem_q - moved;
    end
  end

  // Operand register: write data on accept, read bytes as they land
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      op_q <= DATA_RST;
    end else if (accept) begin
      op_q <= req.write ? req.wdata : DATA_RST;
    end else if (in_run && term_ack && !write_q) begin
      op_q <= rd_next;
    end
  end

  // Write lanes are loaded at the end of setup, on the same edge that raises the strobe
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      data_q <= DATA_RST;
    end else if (state_q == ST_SETUP) begin
      data_q <= wr_mux;
    end
  end

  // End of operand and its status
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      done_q   <= 1'b0;
      status_q <= STAT_RST;
    end else begin
      done_q <= in_run && term_any && !(term_ack && !last);
      if (in_run && term_any) begin
        if (pin_s.bus_error_in && pin_s.halt_in) begin
          status_q <= STAT_RETRY;
        end else if (pin_s.bus_error_in) begin
          status_q <= STAT_BUS_ERROR_IN;
        end else if (term_autovector_req) begin
          status_q <= STAT_AUTOVECTOR_REQ;
        end else begin
          status_q <= STAT_OK;
        end
      end
    end
  end

  // The last termination stays in the synchroniser for a few edges;
  // a new operand waits so its first cycle cannot end on it.
  assign req_ready              = (state_q == ST_IDLE) && !term_any;
  assign rsp_valid              = done_q;
  assign rsp.rdata              = op_q;
  assign rsp.status             = status_q;
  assign pins_out.addr          = addr_q;
  assign pins_out.xfer_size_hi  = rem_q[1];
  assign pins_out.xfer_size_lo  = rem_q[0];
  assign pins_out.rd_wr_n       = !write_q;
  assign pins_out.strobe        = in_run;
  assign pins_out.data          = data_q;
  assign pins_out.data_oe_n     = !(write_q && (state_q == ST_SETUP || in_run));

  // Checks
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  property p_wait;
    in_run && !term_any |=> in_run && $stable(addr_q) && $stable(rem_q);
  endproperty
  a_wait: assert property (p_wait)
    else $error("cycle left without termination");

  property p_read_end;
    in_run && term_ack && !write_q |=> !in_run && op_q == $past(rd_next);
  endproperty
  a_read_end: assert property (p_read_end)
    else $error("read acknowledge did not end cycle or capture");

  property p_size8;
    in_run && term_ack && ack == ACK_8
      |=> rsp_valid || rem_q == $past(rem_q) - 3'h1;
  endproperty
  a_size8: assert property (p_size8)
    else $error("8-bit port moved other than one byte");

  property p_bus_error_in;
    in_run && pin_s.bus_error_in && !pin_s.halt_in
      |=> rsp_valid && rsp.status == STAT_BUS_ERROR_IN && state_q == ST_IDLE;
  endproperty
  a_bus_error_in: assert property (p_bus_error_in)
    else $error("bus error not reported");

  property p_bus_error_in_ack;
    in_run && pin_s.bus_error_in && ack_any && !pin_s.halt_in
      |=> $stable(rem_q) && $stable(addr_q) && rsp.status == STAT_BUS_ERROR_IN;
  endproperty
  a_bus_error_in_ack: assert property (p_bus_error_in_ack)
    else $error("acknowledge won over bus error");

  property p_retry;
    in_run && pin_s.bus_error_in && pin_s.halt_in
      |=> rsp_valid && rsp.status == STAT_RETRY;
  endproperty
  a_retry: assert property (p_retry)
    else $error("retry not reported");

  property p_autovector_req_ignored;
    in_run && pin_s.autovector_req && !intack_q && !ack_any
      && !pin_s.bus_error_in |=> in_run;
  endproperty
  a_autovector_req_ignored: assert property (p_autovector_req_ignored)
    else $error("autovector ended a normal cycle");

  property p_long16;
    in_run && term_ack && ack == ACK_16 && rem_q == REM_LONG
      && addr_q[1:0] == 2'h0
      |=> state_q == ST_GAP && rem_q == REM_WORD && addr_q[1:0] == 2'h2;
  endproperty
  a_long16: assert property (p_long16)
    else $error("long word to 16-bit port not split in two");

  property p_start;
    accept && req.nbytes == REM_LONG
      |=> {pins_out.xfer_size_hi, pins_out.xfer_size_lo} == 2'h0
      ##1 pins_out.strobe;
  endproperty
  a_start: assert property (p_start)
    else $error("long word did not start as full size");

  property p_advance;
    in_run && term_ack && !last
      |=> addr_q == $past(addr_q) + ADDR_W'($past(moved))
      ##1 rem_q == $past(rem_q, 2) - $past(moved, 2);
  endproperty
  a_advance: assert property (p_advance)
    else $error("address or size not advanced");

  property p_byte_lanes;
    state_q == ST_SETUP && rem_q == REM_BYTE
      |=> data_q == {4{byte_of(op_q, 2'h3)}};
  endproperty
  a_byte_lanes: assert property (p_byte_lanes)
    else $error("byte write not on all lanes");

  c_long8: cover property (in_run && term_ack && ack == ACK_8
                           && rem_q == REM_LONG);
  c_retry: cover property (in_run && pin_s.bus_error_in && pin_s.halt_in);
  c_autovector_req:  cover property (in_run && term_autovector_req);
  c_misal: cover property (in_run && term_ack && write_q
                           && addr_q[0] && !last);

endmodule : bus_sizing_seq

// [testbench/slave_port_model.sv]
// Slave port model: own width, wait states and termination kinds on demand
`timescale 1ns/1ns

module slave_port_model
  import bus_sizing_pkg::*;
(
  input  wire logic        ref_clk, // Bus clock
  input  wire logic        rst,     // Async reset, active high
  input  wire bus_out_t    bus_o,   // Device outputs
  input  wire logic [31:0] data_w,  // Resolved data wire
  input  wire logic [1:0]  port_w,  // Own width as acknowledge code
  input  wire logic [2:0]  waits,   // Wait cycles before answering
  input  wire logic [2:0]  mode,    // 0 ack,1 err,2 retry,3 err+ack,4 vec,5 vec+ack,6 halt+ack
  output bus_in_t          bus_i    // Termination pins and read data
);
  logic [7:0]  mem [0:63];
  logic [2:0]  cnt_q;
  logic        done_q;
  logic [31:0] rd;
  logic        ack;
  int          w;
  int          off;
  int          n;
  int          b;

  initial for (int i = 0; i < 64; i++) mem[i] = 8'(i);

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      bus_i  <= '0;
      cnt_q  <= 3'h0;
      done_q <= 1'b0;
    end else if (!bus_o.strobe) begin
      // Terminations drop and released data keeps changing so a stale value never reads as valid
      bus_i  <= {5'h00, ~bus_i.data};
      cnt_q  <= 3'h0;
      done_q <= 1'b0;
    end else if (!done_q && cnt_q != waits) begin
      cnt_q <= cnt_q + 3'h1;
      // Early autovector outside interrupt acknowledge must not end the cycle
      bus_i.autovector_req <= (mode == 3'h5);
    end else if (!done_q) begin
      w   = (port_w == ACK_32) ? 4 : (port_w == ACK_16) ? 2 : 1;
      off = int'(bus_o.addr[1:0]) % w;
      b   = int'(bus_o.addr[5:0]) - off;
      n   = ({bus_o.xfer_size_hi, bus_o.xfer_size_lo} == 2'h0) ? 4 :
            int'({bus_o.xfer_size_hi, bus_o.xfer_size_lo});
      ack = mode inside {3'h0, 3'h3, 3'h5, 3'h6};
      rd  = ~bus_i.data;
      for (int k = 0; k < w; k++) rd[31-8*k -: 8] = mem[b+k];
      if (!bus_o.rd_wr_n && ack && mode != 3'h3) begin
        for (int k = off; k < w && k < off + n; k++) mem[b+k] = data_w[31-8*k -: 8];
      end
      done_q <= 1'b1;
      bus_i  <= {ack & port_w[1], ack & port_w[0], (mode inside {3'h1, 3'h2, 3'h3}),
                 (mode inside {3'h2, 3'h6}), (mode inside {3'h4, 3'h5}), rd};
    end
  end
endmodule : slave_port_model

// [testbench/testbench.sv]
// Self-checking bench for the bus sizing sequencer
`timescale 1ns/1ns

module testbench
  import bus_sizing_pkg::*;
;
  logic        ref_clk = 1'b0;
  logic        rst = 1'b1;
  logic        req_valid = 1'b0;
  logic        req_ready;
  op_req_t     req = '0;
  logic        rsp_valid;
  op_rsp_t     rsp;
  bus_in_t     pins_in;
  bus_out_t    pins_out;
  bus_in_t     slv;
  logic [31:0] data_w;
  logic [1:0]  siz;
  logic [1:0]  port_w = ACK_32;
  logic [2:0]  waits = 3'h0;
  logic [2:0]  mode = 3'h0;
  logic [7:0]  shadow [0:63];
  logic [31:0] exp_a = 32'h0;
  logic        st_q = 1'b0;
  logic [1:0]  pws [3] = '{ACK_32, ACK_16, ACK_8};
  logic [2:0]  szs [3] = '{REM_BYTE, REM_WORD, REM_LONG};
  logic [1:0]  exp_st [7] = '{STAT_OK, STAT_BUS_ERROR_IN, STAT_RETRY, STAT_BUS_ERROR_IN,
                              STAT_AUTOVECTOR_REQ, STAT_OK, STAT_OK};
  int          fails = 0;
  int          comparisons = 0;
  int          cycles = 0;
  int          n_bus = 0;
  int          rem = 0;
  int          mm = 0;
  int          w = 4;

  always #50 ref_clk = ~ref_clk;
  // Device owns the data wire while its enable is low
  assign data_w  = pins_out.data_oe_n ? slv.data : pins_out.data;
  assign pins_in = {slv[DATA_W+4:DATA_W], data_w};
  assign siz     = {pins_out.xfer_size_hi, pins_out.xfer_size_lo};

  bus_sizing_seq dut (.ref_clk(ref_clk), .rst(rst), .req_valid(req_valid),
    .req_ready(req_ready), .req(req), .rsp_valid(rsp_valid), .rsp(rsp),
    .pins_in(pins_in), .pins_out(pins_out));

  slave_port_model slave (.ref_clk(ref_clk), .rst(rst), .bus_o(pins_out), .data_w(data_w),
    .port_w(port_w), .waits(waits), .mode(mode), .bus_i(slv));

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic summarize();
    if (fails == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : summarize

  // Bytes one bus cycle can move at this address for the current port
  function automatic int step(input logic [31:0] a, input int r);
    int m;
    m = w - int'(a[1:0]) % w;
    return (m < r) ? m : r;
  endfunction : step

  always @(negedge ref_clk) begin
    if (pins_out.strobe && !st_q && rem > 0) begin
      chk("cycle address", exp_a, pins_out.addr);
      chk("size outputs", 32'(rem % 4), {30'h0, siz});
      n_bus++;
      mm = step(exp_a, rem);
      exp_a += 32'(mm);
      rem -= mm;
    end
    st_q = pins_out.strobe;
  end

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 40000) begin
      fails++;
      summarize();
    end
  end

  task automatic op(input logic [31:0] a, input logic [2:0] nb, input logic wr,
                    input logic ia, input logic [31:0] wd, input logic [1:0] st);
    logic [31:0] er;
    logic [31:0] msk;
    logic [31:0] ea;
    int          c;
    int          r;
    int          t;
    msk = (nb == 3'h4) ? 32'hFFFF_FFFF : (32'h1 << (8 * nb)) - 32'h1;
    wd  = wd & msk;
    er  = 32'h0;
    for (int k = 0; k < nb; k++) er = {er[23:0], shadow[6'(a + k)]};
    w  = (port_w == ACK_32) ? 4 : (port_w == ACK_16) ? 2 : 1;
    ea = a;
    r  = nb;
    c  = 0;
    while (r > 0) begin
      t = step(ea, r);
      ea += 32'(t);
      r -= t;
      c++;
    end
    if (st != STAT_OK) c = 1;
    t = 0;
    while (req_ready !== 1'b1 && t < 100) begin
      @(negedge ref_clk);
      t++;
    end
    req       = '{addr: a, nbytes: nb, write: wr, intack: ia, wdata: wd};
    req_valid = 1'b1;
    exp_a     = a;
    rem       = nb;
    n_bus     = 0;
    @(negedge ref_clk);
    req_valid = 1'b0;
    t = 0;
    while (rsp_valid !== 1'b1 && t < 400) begin
      @(negedge ref_clk);
      t++;
    end
    chk("response", 32'h1, {31'h0, rsp_valid});
    chk("status", {30'h0, st}, {30'h0, rsp.status});
    chk("bus cycles", 32'(c), 32'(n_bus));
    if (!wr && st == STAT_OK) chk("read data", er, rsp.rdata & msk);
    if (wr && st == STAT_OK) begin
      for (int k = 0; k < nb; k++) shadow[6'(a + k)] = wd[8 * (int'(nb) - 1 - k) +: 8];
    end
  endtask : op

  initial begin
    void'($urandom(32'hB931));
    for (int i = 0; i < 64; i++) shadow[i] = 8'(i);
    repeat (16) @(posedge ref_clk);
    @(negedge ref_clk);
    rst = 1'b0;
    // Every width, offset and size, written then read back
    foreach (pws[p]) begin
      for (int o = 0; o < 4; o++) begin
        foreach (szs[s]) begin
          port_w = pws[p];
          op(32'h100 + o, szs[s], 1'b1, 1'b0, $urandom, STAT_OK);
          op(32'h100 + o, szs[s], 1'b0, 1'b0, 32'h0, STAT_OK);
        end
      end
    end
    // Width changes from one operand to the next
    repeat (150) begin
      port_w = pws[$urandom % 3];
      waits  = 3'($urandom % 6);
      op($urandom, szs[$urandom % 3], 1'($urandom), 1'b0, $urandom, STAT_OK);
    end
    waits  = 3'h7;
    port_w = ACK_32;
    for (int m = 1; m < 7; m++) begin
      mode = 3'(m);
      op(32'h200, REM_LONG, 1'b0, m == 4, 32'h0, exp_st[m]);
    end
    mode  = 3'h0;
    waits = 3'h0;
    summarize();
  end
endmodule : testbench
